// ### common/acs_pkg.sv
package acs_pkg;

    // Register index width; byte address is four times the index.
    localparam int REG_IDX_W = 5;
    localparam logic [4:0] IDX_SETUP_X = 5'h0E;
    localparam logic [4:0] IDX_SETUP_Y = 5'h0F;
    localparam logic [4:0] IDX_THR_XP = 5'h10;
    localparam logic [4:0] IDX_THR_YP = 5'h11;
    localparam logic [4:0] IDX_THR_XN = 5'h12;
    localparam logic [4:0] IDX_THR_YN = 5'h13;
    localparam logic [4:0] IDX_STATUS = 5'h14;
    localparam logic [4:0] IDX_LOCK = 5'h18;

    // Arming setup field positions and widths.
    localparam int WIN_POS_LSB = 0;
    localparam int WIN_NEG_LSB = 2;
    localparam int STRETCH_LSB = 4;
    localparam int SETUP_USED_W = 6;
    localparam int LOCK_BIT = 0;

    // Reset values.
    localparam logic [5:0] SETUP_RESET = 6'h0F;
    localparam logic [7:0] THR_RESET = 8'h00;
    localparam logic [7:0] THR_DISABLED = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h11;

    // Status bit positions.
    localparam int ST_INTERNAL_FAULT = 6;
    localparam int ST_OVERRANGE = 5;
    localparam int ST_INIT = 4;
    localparam int ST_MISMATCH = 3;
    localparam int ST_OFFSET_Y = 2;
    localparam int ST_OFFSET_X = 1;
    localparam int ST_RESET = 0;
    localparam logic [7:0] STATUS_CLR_MASK = 8'h6F;

    // Window size base: size is this value shifted left by the field.
    localparam logic [4:0] WIN_BASE = 5'h02;

    // Stretch times in microseconds, upper figures, and the clock rate.
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned STRETCH1_US = 16384;
    localparam int unsigned STRETCH2_US = 65536;
    localparam int unsigned STRETCH3_US = 262016;
    localparam int unsigned STRETCH1_CYC = STRETCH1_US * CLK_MHZ;
    localparam int unsigned STRETCH2_CYC = STRETCH2_US * CLK_MHZ;
    localparam int unsigned STRETCH3_CYC = STRETCH3_US * CLK_MHZ;
    localparam int STRETCH_CNT_W = 32;

    typedef enum logic [1:0] {
        ARM_OFF,
        ARM_MOVING_AVG,
        ARM_COUNT,
        ARM_UNFILTERED
    } acs_arm_mode_type;

    typedef struct packed {
        logic axisEn;
        logic posEn;
        logic negEn;
        logic [7:0] thrPos;
        logic [7:0] thrNeg;
        logic [4:0] winPos;
        logic [4:0] winNeg;
        logic [3:0] countLimit;
    } acs_axis_cfg_type;

    typedef struct packed {
        logic internalFault;
        logic overrange;
        logic mismatch;
        logic offsetY;
        logic offsetX;
    } acs_status_evt_type;

    typedef struct packed {
        logic [7:0] setupX;
        logic [7:0] setupY;
        logic [7:0] thrXP;
        logic [7:0] thrYP;
        logic [7:0] thrXN;
        logic [7:0] thrYN;
    } acs_crc_image_type;

endpackage : acs_pkg

// ### rtl/acs_pulse_stretch.sv
module acs_pulse_stretch #(
    parameter int CNT_W = acs_pkg::STRETCH_CNT_W
) (
    // Clock, reset and clock enable.
    input logic sys_clk,
    input logic rst,
    input logic ce,
    // Condition and stretch setting.
    input logic axisEn,
    input logic cond,
    input logic [CNT_W-1:0] loadTicks,
    // Stretched arming output.
    output logic armOut
);

    logic [CNT_W-1:0] cntQ;
    logic [CNT_W-1:0] cntD;
    logic outQ;
    logic outD;
    wire cntBusy = (cntQ != '0);

    // The hold counter reloads while the condition stands, so a recurrence restarts it.
    always_comb begin
        cntD = cntQ;
        if (!axisEn) begin
            cntD = '0;
        end else if (cond) begin
            cntD = loadTicks;
        end else if (cntBusy) begin
            cntD = cntQ - 1'b1;
        end
        outD = axisEn & (cond | cntBusy);
    end

    // Output is a flop so downstream pin logic sees no glitches.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cntQ <= '0;
            outQ <= 1'b0;
        end else if (ce) begin
            cntQ <= cntD;
            outQ <= outD;
        end
    end

    assign armOut = outQ;

endmodule : acs_pulse_stretch

// ### rtl/acs_arming_regs.sv
// Function
// - Stretch field selects none, 16, 65, 262 ms.
// - Stretch time counted from internal clock.
// - Window fields meaning follows arming mode.
// - Moving average sizes 2, 4, 8, 16.
// - Count limit from positive field only.
// - Four independent unsigned 8-bit thresholds.
// - Threshold count equals one output LSB.
// - Zero threshold disables that polarity only.
// - Both zero disables axis and pin.
// - Threshold writes ignored after init lock.
// - Thresholds included in writable register CRC.
// - Status read clears transient flags.
// - Status layout bits 7 down to 0.
// - Init flag self clears, read keeps it.
module acs_arming_regs #(
    parameter int unsigned STRETCH1_CYC = acs_pkg::STRETCH1_CYC,
    parameter int unsigned STRETCH2_CYC = acs_pkg::STRETCH2_CYC,
    parameter int unsigned STRETCH3_CYC = acs_pkg::STRETCH3_CYC
) (
    // Clock, reset and clock enable.
    input logic sys_clk,
    input logic rst,
    input logic ce,
    // Avalon-MM slave, word addressed by register index.
    input logic [acs_pkg::REG_IDX_W-1:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [31:0] avs_writedata,
    input logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Status sources from device logic on this clock.
    input logic initDone,
    input acs_pkg::acs_status_evt_type statusEvt,
    // Arming datapath.
    input acs_pkg::acs_arm_mode_type armMode,
    input logic armCondX,
    input logic armCondY,
    output acs_pkg::acs_axis_cfg_type axisCfgX,
    output acs_pkg::acs_axis_cfg_type axisCfgY,
    output logic armOutX,
    output logic armOutY,
    // Lock and CRC engine view.
    output logic initDoneLock,
    output acs_pkg::acs_crc_image_type crcImage
);

    localparam int CW = acs_pkg::STRETCH_CNT_W;
    localparam int SW = acs_pkg::SETUP_USED_W;

    // Register storage.
    logic [SW-1:0] setupXQ;
    logic [SW-1:0] setupYQ;
    logic [7:0] thrXPQ;
    logic [7:0] thrYPQ;
    logic [7:0] thrXNQ;
    logic [7:0] thrYNQ;
    logic [7:0] statusQ;
    logic [7:0] statusD;
    logic lockQ;
    logic ackQ;
    logic [31:0] readDataQ;
    logic [31:0] readDataD;
    acs_pkg::acs_axis_cfg_type cfgXQ;
    acs_pkg::acs_axis_cfg_type cfgYQ;

    // Bus handshake: the first edge of a request captures read data, the second accepts.
    wire reqValid = avs_read | avs_write;
    wire accept = reqValid & ackQ & ce;
    wire wrAccept = accept & avs_write & avs_byteenable[0];
    wire rdAccept = accept & avs_read;
    assign avs_waitrequest = reqValid & ~ackQ;

    // Address decode.
    wire selSetupX = (avs_address == acs_pkg::IDX_SETUP_X);
    wire selSetupY = (avs_address == acs_pkg::IDX_SETUP_Y);
    wire selThrXP = (avs_address == acs_pkg::IDX_THR_XP);
    wire selThrYP = (avs_address == acs_pkg::IDX_THR_YP);
    wire selThrXN = (avs_address == acs_pkg::IDX_THR_XN);
    wire selThrYN = (avs_address == acs_pkg::IDX_THR_YN);
    wire selStatus = (avs_address == acs_pkg::IDX_STATUS);
    wire selLock = (avs_address == acs_pkg::IDX_LOCK);

    // Configuration writes are allowed only until the lock is set.
    wire cfgWrOpen = wrAccept & ~lockQ;
    wire [7:0] wrByte = avs_writedata[7:0];
    // Bits 7:6 are not stored; the host keeps them zero and they read as zero.
    wire [SW-1:0] wrSetup = wrByte[SW-1:0];

    // Read multiplexer; unmapped indices read zero.
    always_comb begin
        readDataD = 32'h0000_0000;
        case (1'b1)
            selSetupX: readDataD[SW-1:0] = setupXQ;
            selSetupY: readDataD[SW-1:0] = setupYQ;
            selThrXP: readDataD[7:0] = thrXPQ;
            selThrYP: readDataD[7:0] = thrYPQ;
            selThrXN: readDataD[7:0] = thrXNQ;
            selThrYN: readDataD[7:0] = thrYNQ;
            selStatus: readDataD[7:0] = statusQ;
            selLock: readDataD[acs_pkg::LOCK_BIT] = lockQ;
            default: readDataD = 32'h0000_0000;
        endcase
    end

    // Bus response flops; read data stands until the next read request captures anew.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ackQ <= 1'b0;
            readDataQ <= 32'h0000_0000;
        end else if (ce) begin
            ackQ <= reqValid & ~ackQ;
            if (reqValid & ~ackQ & avs_read) begin
                readDataQ <= readDataD;
            end
        end
    end
    assign avs_readdata = readDataQ;

    // Writable configuration and threshold registers.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            setupXQ <= acs_pkg::SETUP_RESET;
            setupYQ <= acs_pkg::SETUP_RESET;
            thrXPQ <= acs_pkg::THR_RESET;
            thrYPQ <= acs_pkg::THR_RESET;
            thrXNQ <= acs_pkg::THR_RESET;
            thrYNQ <= acs_pkg::THR_RESET;
        end else if (ce && cfgWrOpen) begin
            if (selSetupX) setupXQ <= wrSetup;
            if (selSetupY) setupYQ <= wrSetup;
            if (selThrXP) thrXPQ <= wrByte;
            if (selThrYP) thrYPQ <= wrByte;
            if (selThrXN) thrXNQ <= wrByte;
            if (selThrYN) thrYNQ <= wrByte;
        end
    end

    // The lock is set once and only a reset releases it.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lockQ <= 1'b0;
        end else if (ce && wrAccept && selLock && wrByte[acs_pkg::LOCK_BIT]) begin
            lockQ <= 1'b1;
        end
    end
    assign initDoneLock = lockQ;

    // Status next state. Only flags that were actually captured for the read are
    // cleared, so an event landing between capture and accept is not lost, and
    // a new event always wins over the clear.
    wire statusRdClr = rdAccept & selStatus;
    wire [7:0] clrMask = statusRdClr ? (acs_pkg::STATUS_CLR_MASK & readDataQ[7:0])
                                     : 8'h00;
    always_comb begin
        statusD = statusQ & ~clrMask;
        statusD[acs_pkg::ST_INTERNAL_FAULT] = statusD[acs_pkg::ST_INTERNAL_FAULT]
                                            | statusEvt.internalFault;
        statusD[acs_pkg::ST_OVERRANGE] = statusD[acs_pkg::ST_OVERRANGE] | statusEvt.overrange;
        statusD[acs_pkg::ST_MISMATCH] = statusD[acs_pkg::ST_MISMATCH] | statusEvt.mismatch;
        statusD[acs_pkg::ST_OFFSET_Y] = statusD[acs_pkg::ST_OFFSET_Y] | statusEvt.offsetY;
        statusD[acs_pkg::ST_OFFSET_X] = statusD[acs_pkg::ST_OFFSET_X] | statusEvt.offsetX;
        // The init flag ignores the read clear and drops only on completion.
        statusD[acs_pkg::ST_INIT] = statusQ[acs_pkg::ST_INIT] & ~initDone;
        statusD[7] = 1'b0;
    end

    // After reset the reset and init flags stand until their clearing events.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            statusQ <= acs_pkg::STATUS_RESET;
        end else if (ce) begin
            statusQ <= statusD;
        end
    end

    // Per-axis decode of setup and thresholds into the arming configuration.
    function automatic acs_pkg::acs_axis_cfg_type cfgDecode(
        input logic [SW-1:0] setup,
        input logic [7:0] thrP,
        input logic [7:0] thrN,
        input acs_pkg::acs_arm_mode_type mode
    );
        acs_pkg::acs_axis_cfg_type c;
        logic [1:0] wp;
        logic [1:0] wn;
        logic [4:0] limWide;
        wp = setup[acs_pkg::WIN_POS_LSB +: 2];
        wn = setup[acs_pkg::WIN_NEG_LSB +: 2];
        limWide = (acs_pkg::WIN_BASE << wp) - 5'h01;
        c = '0;
        // Thresholds pass through unscaled: one count is one output LSB.
        c.thrPos = thrP;
        c.thrNeg = thrN;
        c.posEn = (thrP != acs_pkg::THR_DISABLED);
        c.negEn = (thrN != acs_pkg::THR_DISABLED);
        c.axisEn = c.posEn | c.negEn;
        if (mode == acs_pkg::ARM_MOVING_AVG) begin
            c.winPos = acs_pkg::WIN_BASE << wp;
            c.winNeg = acs_pkg::WIN_BASE << wn;
        end else if (mode == acs_pkg::ARM_COUNT) begin
            c.countLimit = limWide[3:0];
        end
        return c;
    endfunction : cfgDecode

    wire acs_pkg::acs_axis_cfg_type cfgXD = cfgDecode(setupXQ, thrXPQ, thrXNQ, armMode);
    wire acs_pkg::acs_axis_cfg_type cfgYD = cfgDecode(setupYQ, thrYPQ, thrYNQ, armMode);

    // Registered so the datapath sees a clean copy one cycle after any change.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfgXQ <= '0;
            cfgYQ <= '0;
        end else if (ce) begin
            cfgXQ <= cfgXD;
            cfgYQ <= cfgYD;
        end
    end
    assign axisCfgX = cfgXQ;
    assign axisCfgY = cfgYQ;

    // Stretch length select; counts are cycles of the internal clock.
    function automatic logic [CW-1:0] stretchTicks(input logic [1:0] sel);
        logic [CW-1:0] t;
        case (sel)
            2'h1: t = CW'(STRETCH1_CYC);
            2'h2: t = CW'(STRETCH2_CYC);
            2'h3: t = CW'(STRETCH3_CYC);
            default: t = '0;
        endcase
        return t;
    endfunction : stretchTicks

    wire [1:0] stretchSelX = setupXQ[acs_pkg::STRETCH_LSB +: 2];
    wire [1:0] stretchSelY = setupYQ[acs_pkg::STRETCH_LSB +: 2];
    wire [CW-1:0] loadX = stretchTicks(stretchSelX);
    wire [CW-1:0] loadY = stretchTicks(stretchSelY);

    // A disabled axis drives its arming output low from the edge after its enable drops.
    acs_pulse_stretch #(
        .CNT_W(CW)
    ) u_stretch_x (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .axisEn(cfgXQ.axisEn),
        .cond(armCondX),
        .loadTicks(loadX),
        .armOut(armOutX)
    );

    acs_pulse_stretch #(
        .CNT_W(CW)
    ) u_stretch_y (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .axisEn(cfgYQ.axisEn),
        .cond(armCondY),
        .loadTicks(loadY),
        .armOut(armOutY)
    );

    // Writable image for the CRC engine, thresholds included.
    always_comb begin
        crcImage.setupX = {2'b00, setupXQ};
        crcImage.setupY = {2'b00, setupYQ};
        crcImage.thrXP = thrXPQ;
        crcImage.thrYP = thrYPQ;
        crcImage.thrXN = thrXNQ;
        crcImage.thrYN = thrYNQ;
    end

endmodule : acs_arming_regs

// ### testbench/acs_arming_regs_asserts.sv
module acs_arming_regs_asserts (
    // Clock, reset and clock enable.
    input logic sys_clk,
    input logic rst,
    input logic ce,
    // Register bus.
    input logic avs_read,
    input logic avs_write,
    input logic [acs_pkg::REG_IDX_W-1:0] avs_address,
    input logic [31:0] avs_readdata,
    input logic avs_waitrequest,
    // Arming view.
    input acs_pkg::acs_arm_mode_type armMode,
    input logic armCondX,
    input acs_pkg::acs_axis_cfg_type axisCfgX,
    input acs_pkg::acs_axis_cfg_type axisCfgY,
    input logic armOutX,
    input logic armOutY,
    input logic initDoneLock,
    input acs_pkg::acs_crc_image_type crcImage
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // Plain nets, so that every sampled-value call sees a single signal.
    wire req = avs_read | avs_write;
    wire [7:0] thrYP = crcImage.thrYP;
    wire anyThrX = |(crcImage.thrXP | crcImage.thrXN);
    wire [1:0] posFieldX = crcImage.setupX[1:0];
    wire [1:0] stretchX = crcImage.setupX[5:4];

    // An X condition has just ended while its output was up.
    sequence s_cond_end(logic [1:0] sel);
        $fell(armCondX) && armOutX && stretchX == sel;
    endsequence

    property p_one_wait;
        req && avs_waitrequest && ce |=> !avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("bus answer not after one wait");
    property p_rd_width;
        avs_read && !avs_waitrequest |->
            avs_readdata[31:8] == 24'h0 && (avs_address != acs_pkg::IDX_STATUS || !avs_readdata[7]);
    endproperty
    a_rd_width: assert property (p_rd_width) else $error("read data upper bits set");
    property p_pos_en;
        ce |=> axisCfgY.posEn == (|$past(thrYP)) && axisCfgY.thrPos == $past(thrYP);
    endproperty
    a_pos_en: assert property (p_pos_en) else $error("positive enable wrong");
    property p_axis_en;
        ce |=> axisCfgX.axisEn == $past(anyThrX);
    endproperty
    a_axis_en: assert property (p_axis_en) else $error("axis enable wrong");
    property p_pin_off;
        !axisCfgY.axisEn [*2] |-> !armOutY;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("disabled axis output high");
    property p_win_ma;
        armMode == acs_pkg::ARM_MOVING_AVG && ce |=> axisCfgX.winPos == 5'h02 << $past(posFieldX);
    endproperty
    a_win_ma: assert property (p_win_ma) else $error("window size wrong");
    property p_cnt_lim;
        armMode == acs_pkg::ARM_COUNT && ce |=> axisCfgX.winPos == 5'h00
            && axisCfgX.countLimit == 4'((5'h02 << $past(posFieldX)) - 5'h01);
    endproperty
    a_cnt_lim: assert property (p_cnt_lim) else $error("count limit wrong");
    property p_lock;
        initDoneLock |=> initDoneLock && $stable(crcImage);
    endproperty
    a_lock: assert property (p_lock) else $error("locked register changed");
    // Eight ticks is the short stretch the bench configures.
    property p_stretch1;
        s_cond_end(2'h1) |-> armOutX [*8];
    endproperty
    a_stretch1: assert property (p_stretch1) else $error("stretch cut short");
    property p_stretch0;
        s_cond_end(2'h0) |=> !armOutX;
    endproperty
    a_stretch0: assert property (p_stretch0) else $error("output stretched");
endmodule : acs_arming_regs_asserts

bind acs_arming_regs acs_arming_regs_asserts acs_arming_regs_asserts_inst (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .avs_read(avs_read), .avs_write(avs_write),
    .avs_address(avs_address), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .armMode(armMode), .armCondX(armCondX),
    .axisCfgX(axisCfgX), .axisCfgY(axisCfgY), .armOutX(armOutX), .armOutY(armOutY),
    .initDoneLock(initDoneLock), .crcImage(crcImage)
);

// ### testbench/acs_host_model.sv
module acs_host_model (
    // Clock.
    input logic sys_clk,
    // Bus master side.
    output logic [acs_pkg::REG_IDX_W-1:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    input logic [31:0] avs_readdata,
    input logic avs_waitrequest
);
    timeunit 1ns;
    timeprecision 1ps;

    // An idle bus shows inverted leftovers, so a slave that samples late is caught.
    task automatic release_bus(input logic [4:0] a);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~a;
        avs_writedata <= ~avs_writedata;
        avs_byteenable <= 4'h0;
    endtask : release_bus

    initial begin
        avs_writedata = 32'h0;
        release_bus(5'h00);
    end

    // One transfer; the request stands until waitrequest is seen low at an edge.
    task automatic xfer(input logic [4:0] a, input logic rd, input logic [7:0] d,
                        input logic [3:0] be, output logic [7:0] q);
        logic setup;
        setup = a == acs_pkg::IDX_SETUP_X || a == acs_pkg::IDX_SETUP_Y;
        @(posedge sys_clk);
        avs_address <= a;
        avs_read <= rd;
        avs_write <= !rd;
        avs_byteenable <= be;
        avs_writedata <= {24'h0, setup ? {2'b00, d[5:0]} : d};
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        release_bus(a);
    endtask : xfer
endmodule : acs_host_model

// ### testbench/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic initDone = 1'b0;
    logic armCondX = 1'b0;
    logic armCondY = 1'b0;
    acs_pkg::acs_status_evt_type statusEvt = '0;
    acs_pkg::acs_arm_mode_type armMode = acs_pkg::ARM_MOVING_AVG;
    logic [4:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic armOutX, armOutY, initDoneLock;
    acs_pkg::acs_axis_cfg_type axisCfgX, axisCfgY;
    acs_pkg::acs_crc_image_type crcImage;
    logic [7:0] rdData;
    int nFail = 0;
    int testsRun = 0;
    int cycles = 0;
    logic [7:0] statusBit [5] = '{8'h02, 8'h04, 8'h08, 8'h20, 8'h40};

    always #2.5 sys_clk = ~sys_clk;

    // Short stretch counts keep the run brief.
    acs_arming_regs #(.STRETCH1_CYC(8), .STRETCH2_CYC(16), .STRETCH3_CYC(32)) acs_arming_regs_inst (
        .sys_clk(sys_clk), .rst(rst), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .initDone(initDone), .statusEvt(statusEvt),
        .armMode(armMode), .armCondX(armCondX), .armCondY(armCondY), .axisCfgX(axisCfgX),
        .axisCfgY(axisCfgY), .armOutX(armOutX), .armOutY(armOutY),
        .initDoneLock(initDoneLock), .crcImage(crcImage)
    );
    acs_host_model acs_host_model_inst (
        .sys_clk(sys_clk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest)
    );

    task automatic printVerdict();
        if (nFail == 0 && testsRun > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : printVerdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            nFail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [3:0] be = 4'h1);
        acs_host_model_inst.xfer(a, 1'b0, d, be, rdData);
    endtask : wr

    task automatic rdChk(input logic [4:0] a, input logic [7:0] exp);
        acs_host_model_inst.xfer(a, 1'b1, 8'h00, 4'hF, rdData);
        check(rdData, exp);
    endtask : rdChk

    // Raises either the init completion or the X arming condition for n edges.
    task automatic pulse(input bit onInit, input int n);
        @(posedge sys_clk);
        if (onInit) begin
            initDone <= 1'b1;
        end else begin
            armCondX <= 1'b1;
        end
        repeat (n) @(posedge sys_clk);
        initDone <= 1'b0;
        armCondX <= 1'b0;
    endtask : pulse

    // For a nonzero select the second pulse lands while the output is still held, so the interval restarts.
    task automatic stretchRun(input logic [1:0] sel, input int ticks);
        int n;
        n = 0;
        wr(acs_pkg::IDX_SETUP_X, {2'b00, sel, 4'hF});
        pulse(1'b0, 2);
        repeat (3) @(posedge sys_clk);
        pulse(1'b0, 2);
        do begin
            @(posedge sys_clk);
            n++;
        end while (armOutX === 1'b1 && n < 100);
        check(n, ticks + 2);
    endtask : stretchRun

    // A hang is cut short well above the few hundred cycles the sequence needs.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            nFail++;
            printVerdict();
        end
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 8'h0E; i <= 8'h13; i++) begin
            rdChk(5'(i), i < 8'h10 ? 8'h0F : 8'h00);
        end
        rdChk(acs_pkg::IDX_STATUS, 8'h11);
        rdChk(acs_pkg::IDX_STATUS, 8'h10);
        for (int i = 0; i < 5; i++) begin
            @(posedge sys_clk);
            statusEvt <= 5'(1 << i);
            @(posedge sys_clk);
            statusEvt <= '0;
            rdChk(acs_pkg::IDX_STATUS, 8'h10 | statusBit[i]);
        end
        rdChk(acs_pkg::IDX_STATUS, 8'h10);
        pulse(1'b1, 1);
        rdChk(acs_pkg::IDX_STATUS, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(5'(8'h10 + i), 8'(8'hA1 + 8'h11 * i));
        end
        wr(acs_pkg::IDX_THR_XP, 8'h77, 4'h0);
        wr(5'h1F, 8'h5A);
        rdChk(5'h1F, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rdChk(5'(8'h10 + i), 8'(8'hA1 + 8'h11 * i));
        end
        check({crcImage.thrXP, crcImage.thrYP, crcImage.thrXN, crcImage.thrYN}, 32'hA1B2C3D4);
        for (int f = 0; f < 4; f++) begin
            wr(acs_pkg::IDX_SETUP_X, {4'h0, 2'(3 - f), 2'(f)});
            // The write lands at the accepting edge, so look one edge later.
            @(posedge sys_clk);
            check(crcImage.setupX, {4'h0, 2'(3 - f), 2'(f)});
            for (int m = 0; m < 4; m++) begin
                armMode <= acs_pkg::acs_arm_mode_type'(m);
                repeat (2) @(posedge sys_clk);
                check(axisCfgX.winPos, m == 1 ? 2 << f : 0);
                check(axisCfgX.winNeg, m == 1 ? 2 << (3 - f) : 0);
                check(axisCfgX.countLimit, m == 2 ? (2 << f) - 1 : 0);
            end
        end
        wr(acs_pkg::IDX_THR_XP, 8'h00);
        wr(acs_pkg::IDX_THR_YP, 8'h00);
        wr(acs_pkg::IDX_THR_YN, 8'h00);
        @(posedge sys_clk);
        armCondY <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check({axisCfgX.axisEn, axisCfgX.posEn, axisCfgX.negEn, axisCfgX.thrNeg}, 11'h5C3);
        check({axisCfgY.axisEn, armOutY}, 2'b00);
        wr(acs_pkg::IDX_THR_YN, 8'h01);
        repeat (3) @(posedge sys_clk);
        check({axisCfgY.axisEn, axisCfgY.negEn, armOutY}, 3'b111);
        armCondY <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            stretchRun(2'(s), s == 0 ? 0 : 4 << s);
        end
        // A held clock enable freezes the hold counter, so the output outlasts its stretch.
        pulse(1'b0, 1);
        ce <= 1'b0;
        repeat (40) @(posedge sys_clk);
        check(armOutX, 1'b1);
        ce <= 1'b1;
        wr(acs_pkg::IDX_LOCK, 8'h01);
        rdChk(acs_pkg::IDX_LOCK, 8'h01);
        wr(acs_pkg::IDX_THR_XN, 8'h55);
        wr(acs_pkg::IDX_SETUP_X, 8'h00);
        rdChk(acs_pkg::IDX_THR_XN, 8'hC3);
        rdChk(acs_pkg::IDX_SETUP_X, 8'h3F);
        check(initDoneLock, 1'b1);
        printVerdict();
    end
endmodule : tb_top
